// File: effecter_cmd.sv
`timescale 1ns/10ps
`default_nettype none
// Operation
// - handle 0x0000 and 0xFFFF name nothing
// - composite count must be one to eight
// - set reply is one completion byte
// - illegal selector gives unsupported-state code
// - leave-unchanged selector keeps sub-effecter state
// - apply-change drives sub-effecter to target
// - target decoded against that sub-effecter's state set
// - get request is handle; unknown gives 0x80
// - get reply: code, count, entry per sub
// - get request changes no effecter state
// - condition byte encodes six ordered conditions
// - pending byte shows requested or present state
module effecter_cmd (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_last,
  output logic o_rx_ready,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  output logic o_tx_last,
  input wire logic i_tx_ready
);
  typedef enum logic [1:0] {ST_RX, ST_EXEC, ST_RESP} phase_t;

  // whole block state, registered as one word
  typedef struct packed {
    phase_t st;              // request, execute, reply
    logic [4:0] nb;          // request bytes taken, saturating
    logic [7:0] cmd;         // command selector
    logic [15:0] handle;     // effecter handle
    logic [7:0] cnt;         // composite count
    logic [7:0][7:0] sel;    // change request selector per entry
    logic [7:0][7:0] tgt;    // target state per entry
    logic [7:0] code;        // completion value of current request
    logic [7:0][7:0] present;  // present state per sub-effecter
    logic [7:0][7:0] pending;  // requested state in progress
    logic [7:0] pend;          // update pending flags
    logic [7:0] settle;        // cycles left until pending lands
    logic [4:0] tx_idx;        // reply byte being offered
    logic [7:0] tx_data;       // reply byte register
  } state_t;

  state_t s_q;
  state_t s_d;

  // judge a finished request; checks run most general first
  function automatic logic [7:0] judge(input state_t s);
    logic [7:0] c;
    logic bad_sel;
    logic bad_tgt;
    c = effecter_cmd_pkg::CC_SUCCESS;
    bad_sel = 1'b0;
    bad_tgt = 1'b0;
    for (int i = 0; i < effecter_cmd_pkg::SUBS; i++) begin
      if (8'(i) < s.cnt) begin
        if (s.sel[i] != effecter_cmd_pkg::SEL_LEAVE &&
            s.sel[i] != effecter_cmd_pkg::SEL_APPLY) begin
          bad_sel = 1'b1;
        end
        if (s.sel[i] == effecter_cmd_pkg::SEL_APPLY &&
            (s.tgt[i] < effecter_cmd_pkg::STATE_MIN ||
             s.tgt[i] > effecter_cmd_pkg::STATE_MAX[i])) begin
          bad_tgt = 1'b1;
        end
      end
    end
    if (s.cmd != effecter_cmd_pkg::CMD_SET_STATES &&
        s.cmd != effecter_cmd_pkg::CMD_GET_STATES) begin
      c = effecter_cmd_pkg::CC_UNSUPPORTED_CMD;
    end else if (s.nb < effecter_cmd_pkg::GET_REQ_LEN) begin
      c = effecter_cmd_pkg::CC_INVALID_LENGTH;
    end else if (s.handle == effecter_cmd_pkg::HANDLE_RSVD_LO ||
                 s.handle == effecter_cmd_pkg::HANDLE_RSVD_HI ||
                 s.handle != effecter_cmd_pkg::MY_HANDLE) begin
      c = effecter_cmd_pkg::CC_UNKNOWN_HANDLE;
    end else if (s.cmd == effecter_cmd_pkg::CMD_SET_STATES) begin
      if (s.nb < effecter_cmd_pkg::SET_HDR_LEN) begin
        c = effecter_cmd_pkg::CC_INVALID_LENGTH;
      end else if (s.cnt < effecter_cmd_pkg::COUNT_MIN ||
                   s.cnt > effecter_cmd_pkg::COUNT_MAX) begin
        c = effecter_cmd_pkg::CC_INVALID_DATA;
      end else if ({3'h0, s.nb} !=
                   8'(effecter_cmd_pkg::SET_HDR_LEN) + (s.cnt << 1)) begin
        c = effecter_cmd_pkg::CC_INVALID_LENGTH;
      end else if (bad_sel) begin
        c = effecter_cmd_pkg::CC_UNSUPPORTED_STATE;
      end else if (bad_tgt) begin
        c = effecter_cmd_pkg::CC_INVALID_STATE;
      end
    end else if (s.nb != effecter_cmd_pkg::GET_REQ_LEN) begin
      c = effecter_cmd_pkg::CC_INVALID_LENGTH;
    end
    return c;
  endfunction : judge

  // reply byte at position i: code, count, then cond/pending/present
  function automatic logic [7:0] reply(input state_t s, input logic [4:0] i);
    logic [4:0] off;
    logic [2:0] k;
    logic [4:0] j;
    off = i - 5'h02;
    k = 3'(off / 5'h03);
    j = off % 5'h03;
    if (i == 5'h00) begin
      reply = s.code;
    end else if (i == 5'h01) begin
      reply = effecter_cmd_pkg::COUNT_MAX;
    end else if (j == 5'h00) begin
      // no enable command here, so only the two enabled codes occur
      reply = s.pend[k] ? effecter_cmd_pkg::OP_UPDATE_PENDING
                        : effecter_cmd_pkg::OP_NO_UPDATE;
    end else if (j == 5'h01) begin
      reply = s.pend[k] ? s.pending[k] : s.present[k];
    end else begin
      reply = s.present[k];
    end
  endfunction : reply

  // next-state logic
  always_comb begin
    s_d = s_q;
    // settling timer lands pending states first, so a new apply wins
    if (s_q.settle != 8'h00) begin
      s_d.settle = s_q.settle - 8'h01;
      if (s_q.settle == 8'h01) begin
        for (int i = 0; i < effecter_cmd_pkg::SUBS; i++) begin
          if (s_q.pend[i]) begin
            s_d.present[i] = s_q.pending[i];
          end
        end
        s_d.pend = 8'h00;
      end
    end
    case (s_q.st)
      ST_RX: begin
        // collect request bytes by position
        if (i_rx_valid) begin
          if (s_q.nb != effecter_cmd_pkg::NB_MAX) begin
            s_d.nb = s_q.nb + 5'h01;
          end
          if (s_q.nb == 5'h00) begin
            s_d.cmd = i_rx_data;
          end else if (s_q.nb == effecter_cmd_pkg::IDX_HANDLE_LO) begin
            s_d.handle[7:0] = i_rx_data;
          end else if (s_q.nb == effecter_cmd_pkg::IDX_HANDLE_HI) begin
            s_d.handle[15:8] = i_rx_data;
          end else if (s_q.nb == effecter_cmd_pkg::IDX_COUNT) begin
            s_d.cnt = i_rx_data;
          end else if (s_q.nb < effecter_cmd_pkg::IDX_ENTRY_END) begin
            // entry n lives at bytes 4+2n (selector) and 5+2n (target)
            if (s_q.nb[0] == 1'b0) begin
              s_d.sel[3'((s_q.nb - effecter_cmd_pkg::IDX_ENTRY0) >> 1)] =
                i_rx_data;
            end else begin
              s_d.tgt[3'((s_q.nb - effecter_cmd_pkg::IDX_ENTRY0) >> 1)] =
                i_rx_data;
            end
          end
          if (i_rx_last) begin
            s_d.st = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        s_d.code = judge(s_q);
        // only a clean set request touches the effecters
        if (s_d.code == effecter_cmd_pkg::CC_SUCCESS &&
            s_q.cmd == effecter_cmd_pkg::CMD_SET_STATES) begin
          for (int i = 0; i < effecter_cmd_pkg::SUBS; i++) begin
            if (8'(i) < s_q.cnt &&
                s_q.sel[i] == effecter_cmd_pkg::SEL_APPLY) begin
              s_d.pending[i] = s_q.tgt[i];
              s_d.pend[i] = 1'b1;
              s_d.settle = effecter_cmd_pkg::SETTLE_CYC;
            end
          end
        end
        s_d.tx_idx = 5'h00;
        s_d.tx_data = s_d.code;
        s_d.st = ST_RESP;
      end
      ST_RESP: begin
        // offer reply bytes; errors and set replies are one byte
        if (i_tx_ready) begin
          if (o_tx_last) begin
            s_d.st = ST_RX;
            s_d.nb = 5'h00;
            s_d.sel = '0;
            s_d.cnt = 8'h00;
          end else begin
            s_d.tx_idx = s_q.tx_idx + 5'h01;
            s_d.tx_data = reply(s_d, s_q.tx_idx + 5'h01);
          end
        end
      end
      default: begin
        s_d.st = ST_RX;
      end
    endcase
  end

  // state register with synchronous reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q <= '0;
      s_q.st <= ST_RX;
      s_q.present <= {8{effecter_cmd_pkg::STATE_RESET}};
      s_q.pending <= {8{effecter_cmd_pkg::STATE_RESET}};
    end else begin
      s_q <= s_d;
    end
  end

  // handshake outputs
  assign o_rx_ready = (s_q.st == ST_RX);
  assign o_tx_valid = (s_q.st == ST_RESP);
  assign o_tx_data = s_q.tx_data;
  // full get reply only on success; everything else is one byte
  assign o_tx_last = (s_q.st == ST_RESP) &&
    (s_q.tx_idx == ((s_q.cmd == effecter_cmd_pkg::CMD_GET_STATES &&
                     s_q.code == effecter_cmd_pkg::CC_SUCCESS)
                    ? effecter_cmd_pkg::RSP_GET_LAST
                    : effecter_cmd_pkg::RSP_SET_LAST));

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_reserved_handle: assert property (
    (s_q.st == ST_EXEC && s_q.handle == effecter_cmd_pkg::HANDLE_RSVD_LO)
    |=> o_tx_data != effecter_cmd_pkg::CC_SUCCESS)
    else $error("reserved handle accepted");
  a_count_range: assert property (
    (s_q.st == ST_RESP && s_q.tx_idx == 5'h00 &&
     s_q.cmd == effecter_cmd_pkg::CMD_SET_STATES &&
     o_tx_data == effecter_cmd_pkg::CC_SUCCESS)
    |-> (s_q.cnt >= effecter_cmd_pkg::COUNT_MIN &&
         s_q.cnt <= effecter_cmd_pkg::COUNT_MAX))
    else $error("set accepted with bad count");
  a_set_one_byte: assert property (
    (s_q.st == ST_RESP && s_q.cmd == effecter_cmd_pkg::CMD_SET_STATES)
    |-> o_tx_last)
    else $error("set reply longer than one byte");
  a_bad_selector: assert property (
    (s_q.st == ST_EXEC && s_q.cmd == effecter_cmd_pkg::CMD_SET_STATES &&
     s_q.handle == effecter_cmd_pkg::MY_HANDLE && s_q.nb == 5'h06 &&
     s_q.cnt == 8'h01 && s_q.sel[0] > 8'h01)
    |=> o_tx_data == effecter_cmd_pkg::CC_UNSUPPORTED_STATE)
    else $error("bad selector not reported");
  a_leave_alone: assert property (
    (s_q.st == ST_EXEC && s_q.sel[0] == effecter_cmd_pkg::SEL_LEAVE &&
     !s_q.pend[0]) |=> !s_q.pend[0])
    else $error("leave selector started an update");
  a_apply_target: assert property (
    (s_q.st == ST_RESP && s_q.tx_idx == 5'h00 && s_q.cnt != 8'h00 &&
     s_q.cmd == effecter_cmd_pkg::CMD_SET_STATES &&
     o_tx_data == effecter_cmd_pkg::CC_SUCCESS &&
     s_q.sel[0] == effecter_cmd_pkg::SEL_APPLY)
    |-> (s_q.pend[0] && s_q.pending[0] == s_q.tgt[0]))
    else $error("apply did not start update");
  a_state_legal: assert property (
    s_q.present[1] >= effecter_cmd_pkg::STATE_MIN &&
    s_q.present[1] <= effecter_cmd_pkg::STATE_MAX[1])
    else $error("present state outside state set");
  a_get_length: assert property (
    (s_q.st == ST_RESP && s_q.cmd == effecter_cmd_pkg::CMD_GET_STATES &&
     s_q.code == effecter_cmd_pkg::CC_SUCCESS && s_q.tx_idx < 5'h19)
    |-> !o_tx_last)
    else $error("get reply cut short");
  a_get_static: assert property (
    (s_q.st == ST_EXEC && s_q.cmd == effecter_cmd_pkg::CMD_GET_STATES)
    |=> $stable(s_q.pending))
    else $error("get changed a requested state");
  // a get naming any handle but ours is refused in one byte
  a_get_unknown: assert property (
    (s_q.st == ST_EXEC && s_q.cmd == effecter_cmd_pkg::CMD_GET_STATES &&
     s_q.nb >= effecter_cmd_pkg::GET_REQ_LEN &&
     s_q.handle != effecter_cmd_pkg::MY_HANDLE)
    |=> (o_tx_data == effecter_cmd_pkg::CC_UNKNOWN_HANDLE && o_tx_last))
    else $error("unknown handle not refused");
  // with no enable command only the two enabled conditions can appear
  a_cond_enabled: assert property (
    (s_q.st == ST_RESP && s_q.cmd == effecter_cmd_pkg::CMD_GET_STATES &&
     s_q.code == effecter_cmd_pkg::CC_SUCCESS && s_q.tx_idx >= 5'h02 &&
     (s_q.tx_idx - 5'h02) % 5'h03 == 5'h00)
    |-> o_tx_data <= effecter_cmd_pkg::OP_NO_UPDATE)
    else $error("condition byte out of range");
  a_land_pending: assert property (
    $fell(s_q.pend[0]) |-> s_q.present[0] == $past(s_q.pending[0]))
    else $error("pending state did not land");

  c_set_ok: cover property (s_q.st == ST_RESP && s_q.pend != 8'h00);
  c_get_full: cover property (o_tx_last && s_q.tx_idx == 5'h19);
  c_bad_handle: cover property (
    o_tx_valid && o_tx_data == effecter_cmd_pkg::CC_UNKNOWN_HANDLE);
  // a read-back that lands while a change is still settling
  c_pend_read: cover property (o_tx_valid && s_q.pend != 8'h00 &&
    s_q.cmd == effecter_cmd_pkg::CMD_GET_STATES);
  c_bad_sel: cover property (
    o_tx_valid && o_tx_data == effecter_cmd_pkg::CC_UNSUPPORTED_STATE);
endmodule : effecter_cmd
`default_nettype wire

// File: effecter_cmd_pkg.sv
package effecter_cmd_pkg;
  // command selector byte that opens every request
  localparam logic [7:0] CMD_SET_STATES = 8'h39;
  localparam logic [7:0] CMD_GET_STATES = 8'h3A;
  // reserved handle values and the handle this terminus answers to
  localparam logic [15:0] HANDLE_RSVD_LO = 16'h0000;
  localparam logic [15:0] HANDLE_RSVD_HI = 16'hFFFF;
  localparam logic [15:0] MY_HANDLE = 16'h0010;
  // composite count limits and sub-effecters implemented
  localparam logic [7:0] COUNT_MIN = 8'h01;
  localparam logic [7:0] COUNT_MAX = 8'h08;
  localparam int SUBS = 8;
  // change request selector codes
  localparam logic [7:0] SEL_LEAVE = 8'h00;
  localparam logic [7:0] SEL_APPLY = 8'h01;
  // completion values
  localparam logic [7:0] CC_SUCCESS = 8'h00;
  localparam logic [7:0] CC_INVALID_DATA = 8'h02;
  localparam logic [7:0] CC_INVALID_LENGTH = 8'h03;
  localparam logic [7:0] CC_UNSUPPORTED_CMD = 8'h05;
  localparam logic [7:0] CC_UNKNOWN_HANDLE = 8'h80;
  localparam logic [7:0] CC_INVALID_STATE = 8'h81;
  localparam logic [7:0] CC_UNSUPPORTED_STATE = 8'h82;
  // operational condition codes, in documented order
  localparam logic [7:0] OP_UPDATE_PENDING = 8'h00;
  localparam logic [7:0] OP_NO_UPDATE = 8'h01;
  localparam logic [7:0] OP_DISABLED = 8'h02;
  localparam logic [7:0] OP_UNAVAILABLE = 8'h03;
  localparam logic [7:0] OP_FAILED = 8'h04;
  localparam logic [7:0] OP_IN_TEST = 8'h05;
  // request byte layout: cmd, handle lo, handle hi, count, entries
  localparam logic [4:0] IDX_HANDLE_LO = 5'h01;
  localparam logic [4:0] IDX_HANDLE_HI = 5'h02;
  localparam logic [4:0] IDX_COUNT = 5'h03;
  localparam logic [4:0] IDX_ENTRY0 = 5'h04;
  localparam logic [4:0] IDX_ENTRY_END = 5'h14;
  localparam logic [4:0] GET_REQ_LEN = 5'h03;
  localparam logic [4:0] SET_HDR_LEN = 5'h04;
  localparam logic [4:0] NB_MAX = 5'h1F;
  // response layout: code, count, then three bytes per sub-effecter
  localparam logic [4:0] RSP_SET_LAST = 5'h00;
  localparam logic [4:0] RSP_GET_LAST = 5'h19;
  // highest legal state code per sub-effecter, index 0 is sub 1
  localparam logic [7:0][7:0] STATE_MAX = {8'h02, 8'h03, 8'h04, 8'h02,
                                           8'h05, 8'h02, 8'h03, 8'h02};
  localparam logic [7:0] STATE_MIN = 8'h01;
  localparam logic [7:0] STATE_RESET = 8'h01;
  // settling time of a requested change
  localparam int CLK_NS = 40;
  localparam int SETTLE_NS = 1000;
  localparam logic [7:0] SETTLE_CYC = 8'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
endpackage : effecter_cmd_pkg

// File: mgmt_requester.sv
`timescale 1ns/10ps
`default_nettype none
// management controller model: issues requests, sinks replies
module mgmt_requester (
  input wire logic i_clk,
  input wire logic i_req_ready,
  input wire logic i_slow,
  output logic o_req_valid,
  output logic [7:0] o_req_data,
  output logic o_req_last,
  output logic o_rsp_ready
);
  // idle lines at time zero
  initial begin
    o_req_valid = 1'b0;
    o_req_data = 8'h00;
    o_req_last = 1'b0;
    o_rsp_ready = 1'b0;
  end

  // reply sink: prompt, or stalling at random to stretch replies
  always @(posedge i_clk) begin
    o_rsp_ready <= i_slow ? 1'($urandom % 2) : 1'b1;
  end

  // sends one request byte by byte, each held until taken
  // call just after a rising edge; returns just after one
  task send(input logic [7:0] b[$]);
    logic ok;
    foreach (b[i]) begin
      o_req_valid <= 1'b1;
      o_req_data <= b[i];
      o_req_last <= (i == b.size() - 1);
      // ready is sampled mid-cycle so the edge never races it
      do begin
        @(negedge i_clk) ok = i_req_ready;
        @(posedge i_clk);
      end while (!ok);
    end
    // released data shows the inverse, not a stale byte
    o_req_valid <= 1'b0;
    o_req_last <= 1'b0;
    o_req_data <= ~o_req_data;
    @(posedge i_clk);
  endtask : send
endmodule : mgmt_requester
`default_nettype wire

// File: tb_state_effecter_set_get_cmds.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_state_effecter_set_get_cmds;
  logic i_clk, i_rst, slow;
  logic rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
  logic [7:0] rx_data, tx_data;
  logic [7:0] cur[8], pnd[8], sel[8], tgt[8]; // bench state model
  logic pend[8]; // update pending per sub-effecter
  logic [7:0] rq[$]; // request under construction
  logic [9:0] expq[$]; // notes: skip, last, byte
  logic [9:0] e;
  int failures = 0;
  int checked = 0;

  // 25 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  effecter_cmd uut (.i_clk(i_clk), .i_rst(i_rst), .i_rx_valid(rx_valid),
    .i_rx_data(rx_data), .i_rx_last(rx_last), .o_rx_ready(rx_ready),
    .o_tx_valid(tx_valid), .o_tx_data(tx_data), .o_tx_last(tx_last),
    .i_tx_ready(tx_ready));

  mgmt_requester m (.i_clk(i_clk), .i_req_ready(rx_ready), .i_slow(slow),
    .o_req_valid(rx_valid), .o_req_data(rx_data), .o_req_last(rx_last),
    .o_rsp_ready(tx_ready));

  // each reply byte taken pops the oldest note and is compared with it unless that note is marked skip
  always @(negedge i_clk) begin
    // the request side stays shut while a reply is offered
    if (!i_rst && tx_valid === 1'b1) `CHK(rx_ready, 1'b0)
    if (!i_rst && tx_valid === 1'b1 && tx_ready) begin
      // an unexpected byte meets an unknown note and fails
      e = (expq.size() > 0) ? expq.pop_front() : 10'h0XX;
      if (!e[9]) `CHK({tx_last, tx_data}, e[8:0])
    end
  end

  // notes for a full get reply; subs from live on may be mid-settle
  task exp_get(input int live);
    expq.push_back({2'b00, effecter_cmd_pkg::CC_SUCCESS});
    expq.push_back({2'b00, effecter_cmd_pkg::COUNT_MAX});
    for (int i = 0; i < 8; i++) begin
      expq.push_back({i >= live, 1'b0, pend[i] ?
        effecter_cmd_pkg::OP_UPDATE_PENDING :
        effecter_cmd_pkg::OP_NO_UPDATE});
      expq.push_back({i >= live, 1'b0, pend[i] ? pnd[i] : cur[i]});
      expq.push_back({i >= live, i == 7, cur[i]});
    end
  endtask : exp_get

  task req_get(input logic [15:0] h, input logic [7:0] c, input int live);
    rq = {effecter_cmd_pkg::CMD_GET_STATES, h[7:0], h[15:8]};
    if (c == effecter_cmd_pkg::CC_SUCCESS) exp_get(live);
    else expq.push_back({2'b01, c});
    m.send(rq);
  endtask : req_get

  // set request from sel and tgt; model takes it only on success
  task req_set(input logic [15:0] h, input int n, input logic [7:0] c);
    rq = {effecter_cmd_pkg::CMD_SET_STATES, h[7:0], h[15:8], 8'(n)};
    for (int i = 0; i < n && i < 8; i++) rq = {rq, sel[i], tgt[i]};
    expq.push_back({2'b01, c});
    for (int i = 0; i < n && c == 8'h00; i++) begin
      if (sel[i] == effecter_cmd_pkg::SEL_APPLY) begin
        pend[i] = 1'b1;
        pnd[i] = tgt[i];
      end
    end
    m.send(rq);
  endtask : req_set

  // drain replies, then outwait the 25-cycle settling time
  task settle;
    int k;
    k = 0;
    while (expq.size() > 0 && k < 400) begin
      @(posedge i_clk);
      k++;
    end
    // replies still owed after the limit count as a mismatch
    `CHK(32'(expq.size()), 32'h0)
    repeat (30) @(posedge i_clk);
    foreach (pend[i]) begin
      if (pend[i]) cur[i] = pnd[i];
      pend[i] = 1'b0;
    end
  endtask : settle

  task print_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  // watchdog, far beyond the expected run length
  initial begin
    repeat (40000) @(posedge i_clk);
    failures++;
    print_verdict();
  end

  initial begin
    i_rst = 1'b1;
    slow = 1'b0;
    foreach (cur[i]) begin
      cur[i] = effecter_cmd_pkg::STATE_RESET;
      pend[i] = 1'b0;
    end
    void'($urandom(48));
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    req_get(effecter_cmd_pkg::MY_HANDLE, 8'h00, 8);
    settle();
    // random sets, each read back in full
    for (int t = 0; t < 12; t++) begin
      slow <= 1'($urandom % 2);
      foreach (sel[i]) begin
        sel[i] = 8'($urandom % 2);
        tgt[i] = 8'(1 + $urandom % effecter_cmd_pkg::STATE_MAX[i]);
      end
      req_set(effecter_cmd_pkg::MY_HANDLE, 1 + $urandom % 8, 8'h00);
      settle();
      req_get(effecter_cmd_pkg::MY_HANDLE, 8'h00, 8);
      settle();
    end
    // read back while the change is still pending
    slow <= 1'b0;
    foreach (sel[i]) begin
      sel[i] = (i < 2) ? effecter_cmd_pkg::SEL_APPLY : 8'h00;
      tgt[i] = (cur[i] == 8'h01) ? effecter_cmd_pkg::STATE_MAX[i] : 8'h01;
    end
    req_set(effecter_cmd_pkg::MY_HANDLE, 8, 8'h00);
    req_get(effecter_cmd_pkg::MY_HANDLE, 8'h00, 2);
    settle();
    req_get(effecter_cmd_pkg::MY_HANDLE, 8'h00, 8);
    settle();
    // refused requests, each of which must apply nothing
    for (int k = 0; k < 12; k++) begin
      foreach (sel[i]) begin
        sel[i] = effecter_cmd_pkg::SEL_APPLY;
        tgt[i] = effecter_cmd_pkg::STATE_MIN;
      end
      case (k)
        0: req_set(16'h0000, 8, 8'h80);
        1: req_set(16'hFFFF, 8, 8'h80);
        2: req_set(16'h0010, 0, 8'h02);
        3: req_set(16'h0010, 9, 8'h02);
        4: begin
          sel[3] = 8'h02;
          req_set(16'h0010, 8, 8'h82);
        end
        5: begin
          tgt[2] = 8'h00;
          req_set(16'h0010, 8, 8'h81);
        end
        6: begin
          tgt[7] = effecter_cmd_pkg::STATE_MAX[7] + 8'h01;
          req_set(16'h0010, 8, 8'h81);
        end
        7: begin
          sel[0] = 8'h02;
          req_set(16'h0010, 1, 8'h82);
        end
        8: begin
          // unknown command byte
          rq = {8'h00, 8'h10, 8'h00};
          expq.push_back({2'b01, 8'h05});
          m.send(rq);
        end
        9: begin
          // get with a stray extra byte
          rq = {effecter_cmd_pkg::CMD_GET_STATES, 8'h10, 8'h00, 8'h00};
          expq.push_back({2'b01, 8'h03});
          m.send(rq);
        end
        10: req_get(16'h0000, 8'h80, 8);
        default: req_get(16'h0011, 8'h80, 8);
      endcase
    end
    req_get(effecter_cmd_pkg::MY_HANDLE, 8'h00, 8);
    settle();
    print_verdict();
  end
endmodule : tb_state_effecter_set_get_cmds
`default_nettype wire
